// file: modem_host_pkg.sv
/*
 * shared constants for the packet modem host register bank:
 * register selects, control and mode field positions, buffer size, timing.
 * assumes nothing beyond a systemverilog compiler.
 */
package modem_host_pkg;
    localparam int BUF_DEPTH = 12;
    localparam int PTR_W = 4;
    localparam logic [PTR_W-1:0] PTR_LAST = 4'hB;
    localparam logic [PTR_W-1:0] PTR_ZERO = 4'h0;
    // register selects, {reg_select_hi, reg_select_lo}
    localparam logic [1:0] SEL_DATA = 2'h0;
    localparam logic [1:0] SEL_CMD_STATUS = 2'h1;
    localparam logic [1:0] SEL_CTRL_QUALITY = 2'h2;
    localparam logic [1:0] SEL_MODE = 2'h3;
    // operating_control fields
    localparam int CTL_CLOCK_DIVIDE_SELECT_HI = 7;
    localparam int CTL_CLOCK_DIVIDE_SELECT_LO = 6;
    localparam int CTL_ALTERNATE_CHECKSUM_SELECT = 4;
    localparam int CTL_ALTERNATE_FILTER_SELECT = 3;
    localparam int CTL_TWO_LEVEL = 2;
    localparam int CTL_TOL = 1;
    localparam int CTL_HOLD = 0;
    // operating_mode fields
    localparam int MOD_IRQEN = 7;
    localparam int MOD_INVERT = 6;
    localparam int MOD_TX = 5;
    localparam int MOD_ZP = 4;
    localparam int MOD_POWER_SAVE = 3;
    localparam int MOD_STATUS_SYMBOL_IRQ_ENABLE = 2;
    localparam int MOD_NEXT_STATUS_SYMBOL_HI = 1;
    localparam int MOD_NEXT_STATUS_SYMBOL_LO = 0;
    // modem_status fields
    localparam int STS_IRQ = 7;
    localparam int STS_BUFFER_FREE_FLAG = 6;
    localparam int STS_STATUS_SYMBOL_READY = 5;
    localparam int STS_RECEIVED_STATUS_SYMBOL_HI = 1;
    localparam int STS_RECEIVED_STATUS_SYMBOL_LO = 0;
    localparam logic [7:0] RESET_BYTE = 8'h00;
    localparam logic [2:0] TASK_NULL = 3'h0;
    localparam logic [2:0] TASK_RESET = 3'h7;
    // divide ratios, four-level and two-level
    localparam logic [11:0] DIV4_0 = 12'h200;
    localparam logic [11:0] DIV4_1 = 12'h300;
    localparam logic [11:0] DIV4_2 = 12'h400;
    localparam logic [11:0] DIV4_3 = 12'h600;
    localparam logic [11:0] DIV2_0 = 12'h400;
    localparam logic [11:0] DIV2_1 = 12'h600;
    localparam logic [11:0] DIV2_2 = 12'h800;
    localparam logic [11:0] DIV2_3 = 12'hC00;
    // sync detector tolerances
    localparam logic [2:0] TOL4_LOW = 3'h3;
    localparam logic [2:0] TOL4_HIGH = 3'h7;
    localparam logic [2:0] TOL2 = 3'h5;
    localparam logic [4:0] SETTLE_SYMBOLS = 5'h14;
    localparam int BLOCK_BITS = 94;
    localparam logic [6:0] UNUSED_BIT_IDX = 7'(BLOCK_BITS - 1);
    localparam logic [6:0] BIT_ZERO = 7'h00;
    typedef enum logic [1:0] {
        ENG_IDLE,
        ENG_DRAIN,
        ENG_FILL
    } engine_e;
endpackage

// file: packet_modem_host_registers.sv
/*
 * host register bank of a packet radio modem: data block buffer,
 * command, status, control, mode and quality registers on an 8-bit bus.
 * assumes the host bus and the modem core are synchronous to clk_in and
 * that the core moves buffer words over a valid/ready pair.
 */
// Functional notes
// - two selects pick eight-bit registers, read/write
// - twelve byte buffer, auto advancing pointer
// - control 7:6 chooses crystal divide ratio
// - control bit 4 alternate checksum, four-level
// - control bit 3 alternate filter, four-level
// - control bit 2 two-level; change cancels task
// - four-level sync tolerance three or seven
// - two-level tolerance five, bit ignored
// - control bit 0 freezes level, timing
// - mode bit 7 lets the irq flag pull interrupt pin low
// - mode bit 6 inverts symbol polarity
// - mode bit 5 transmit; change cancels task
// - zero power stops all; commands ignored
// - powersave disables filters, extraction, output
// - twenty symbol settle after powersave ends
// - receive status symbol sets flags, value
// - transmit status symbol sets flags
// - no interrupt for two-level unused bit
// - mode 1:0 picks next transmit symbol
// - task clears free; drain sets free, irq
`timescale 1ns/1ps
module packet_modem_host_registers (
    input wire logic clk_in,
    input wire logic rst_in,
    // host bus
    input wire logic reg_select_lo_in,
    input wire logic reg_select_hi_in,
    input wire logic wr_strobe_in,
    input wire logic rd_strobe_in,
    input wire logic [7:0] wr_data_in,
    output logic [7:0] rd_data_out,
    output logic interrupt_pin_n_out,
    // modem core side: buffer words
    output logic core_word_valid_out,
    input wire logic core_word_ready_in,
    output logic [7:0] core_word_out,
    input wire logic core_word_valid_in,
    output logic core_word_ready_out,
    input wire logic [7:0] core_word_in,
    input wire logic core_block_done_in,
    // modem core side: events and state
    input wire logic status_symbol_event_in,
    input wire logic [1:0] status_symbol_value_in,
    input wire logic [6:0] block_bit_index_in,
    input wire logic symbol_tick_in,
    input wire logic [7:0] signal_quality_in,
    // decoded controls to the core
    output logic [2:0] task_code_out,
    output logic task_start_out,
    output logic task_cancel_out,
    output logic [11:0] symbol_divide_out,
    output logic alternate_checksum_select_out,
    output logic alternate_filter_select_out,
    output logic two_level_mode_out,
    output logic [2:0] sync_error_tolerance_out,
    output logic level_timing_hold_out,
    output logic invert_polarity_out,
    output logic transmit_select_out,
    output logic zero_power_out,
    output logic power_save_out,
    output logic output_settled_out,
    output logic [1:0] next_status_symbol_out
);
    import modem_host_pkg::*;

    typedef struct packed {
        // data block storage, one byte per entry
        logic [BUF_DEPTH-1:0][7:0] buf_mem;
        // host port position
        logic [PTR_W-1:0] host_ptr;
        // core side position
        logic [PTR_W-1:0] core_ptr;
        // two-entry buffer towards the core
        logic [1:0][7:0] skid_data;
        // occupancy of each entry
        logic [1:0] skid_full;
        // entry written next
        logic skid_wr;
        // entry read next
        logic skid_rd;
        // transfer engine state
        engine_e engine;
        // write-only control byte
        logic [7:0] control_reg;
        // write-only mode byte
        logic [7:0] mode_reg;
        // last task code started
        logic [2:0] task_reg;
        // one cycle start strobe
        logic task_start;
        // one cycle cancel strobe
        logic task_cancel;
        // sticky interrupt flag
        logic irq_flag;
        // host may touch the buffer
        logic buffer_free_flag;
        // sticky status symbol flag
        logic status_symbol_ready;
        // last received status symbol
        logic [1:0] received_status_symbol;
        // registered read data
        logic [7:0] rd_data;
        // symbols left before output settles
        logic [4:0] settle_count;
    } state_s;

    state_s state_reg, state_next;

    // shared register select decode
    function automatic logic hit(input logic [1:0] sel, input logic [1:0] want);
        hit = (sel == want);
    endfunction

    // ratio table for the symbol divider
    function automatic logic [11:0] divide_ratio(input logic [1:0] ck, input logic two);
        case (ck)
            2'h0: divide_ratio = two ? DIV2_0 : DIV4_0;
            2'h1: divide_ratio = two ? DIV2_1 : DIV4_1;
            2'h2: divide_ratio = two ? DIV2_2 : DIV4_2;
            default: divide_ratio = two ? DIV2_3 : DIV4_3;
        endcase
    endfunction

    // combined register select
    logic [1:0] sel;

    // transmit direction from the mode byte
    logic tx_mode;

    // two-level operation from the control byte
    logic two_level;

    // host writes the command register
    logic cmd_write;

    // buffer towards the core has room
    logic skid_in_ready;

    // buffer towards the core holds a word
    logic skid_out_valid;

    // status symbol event that may raise flags
    logic ss_event_ok;

    assign sel = {reg_select_hi_in, reg_select_lo_in};
    assign tx_mode = state_reg.mode_reg[MOD_TX];
    assign two_level = state_reg.control_reg[CTL_TWO_LEVEL];
    assign cmd_write = wr_strobe_in && hit(sel, SEL_CMD_STATUS);
    assign skid_in_ready = !state_reg.skid_full[state_reg.skid_wr];
    assign skid_out_valid = state_reg.skid_full[state_reg.skid_rd];
    // the unused two-level block bit raises nothing
    assign ss_event_ok = status_symbol_event_in && state_reg.mode_reg[MOD_STATUS_SYMBOL_IRQ_ENABLE]
        && !(two_level && block_bit_index_in == UNUSED_BIT_IDX);

    // next-state logic for the whole bank
    always_comb begin
        logic push;
        logic pop;
        logic [1:0] sym;
        push = 1'b0;
        pop = 1'b0;
        sym = 2'h0;
        state_next = state_reg;
        state_next.task_start = 1'b0;
        state_next.task_cancel = 1'b0;

        // host writes to the write-only registers
        if (wr_strobe_in && hit(sel, SEL_CTRL_QUALITY)) begin
            state_next.control_reg = wr_data_in;
            if (wr_data_in[CTL_TWO_LEVEL] != two_level) begin
                state_next.task_cancel = 1'b1;
            end
        end
        if (wr_strobe_in && hit(sel, SEL_MODE)) begin
            state_next.mode_reg = wr_data_in;
            if (wr_data_in[MOD_TX] != tx_mode) begin
                state_next.task_cancel = 1'b1;
            end
        end
        // command decode needs the clock, so zero power drops it
        if (cmd_write && !state_reg.mode_reg[MOD_ZP]) begin
            if (wr_data_in[2:0] == TASK_RESET) begin
                state_next.task_cancel = 1'b1;
            end else if (wr_data_in[2:0] != TASK_NULL) begin
                state_next.task_reg = wr_data_in[2:0];
                state_next.task_start = 1'b1;
                state_next.buffer_free_flag = 1'b0;
                state_next.core_ptr = PTR_ZERO;
                state_next.engine = tx_mode ? ENG_DRAIN : ENG_FILL;
            end
        end
        if (state_next.task_cancel) begin
            state_next.engine = ENG_IDLE;
            state_next.buffer_free_flag = 1'b1;
            state_next.skid_full = 2'b00;
        end

        // host side of the buffer: pointer advances per access
        if (wr_strobe_in && hit(sel, SEL_DATA)) begin
            state_next.buf_mem[state_reg.host_ptr] = wr_data_in;
            state_next.host_ptr = (state_reg.host_ptr == PTR_LAST) ? PTR_ZERO
                : state_reg.host_ptr + 1'b1;
        end else if (rd_strobe_in && hit(sel, SEL_DATA)) begin
            state_next.host_ptr = (state_reg.host_ptr == PTR_LAST) ? PTR_ZERO
                : state_reg.host_ptr + 1'b1;
        end
        if (cmd_write || state_next.task_cancel) begin
            state_next.host_ptr = PTR_ZERO;
        end

        // core side: drain to the core through the two-entry skid buffer
        push = (state_reg.engine == ENG_DRAIN) && skid_in_ready && !state_reg.task_cancel;
        pop = skid_out_valid && core_word_ready_in;
        if (push) begin
            state_next.skid_data[state_reg.skid_wr] = state_reg.buf_mem[state_reg.core_ptr];
            state_next.skid_full[state_reg.skid_wr] = 1'b1;
            state_next.skid_wr = ~state_reg.skid_wr;
            if (state_reg.core_ptr == PTR_LAST) begin
                state_next.engine = ENG_IDLE;
                state_next.buffer_free_flag = 1'b1;
                state_next.irq_flag = 1'b1;
            end else begin
                state_next.core_ptr = state_reg.core_ptr + 1'b1;
            end
        end
        if (pop) begin
            state_next.skid_full[state_reg.skid_rd] = 1'b0;
            state_next.skid_rd = ~state_reg.skid_rd;
        end
        // receive fill from the core, block done frees the buffer
        if (state_reg.engine == ENG_FILL && core_word_valid_in) begin
            state_next.buf_mem[state_reg.core_ptr] = core_word_in;
            state_next.core_ptr = (state_reg.core_ptr == PTR_LAST) ? PTR_LAST
                : state_reg.core_ptr + 1'b1;
        end
        if (state_reg.engine == ENG_FILL && core_block_done_in) begin
            state_next.engine = ENG_IDLE;
            state_next.buffer_free_flag = 1'b1;
            state_next.irq_flag = 1'b1;
        end

        // status read clears the sticky flags; new events win over the clear
        if (rd_strobe_in && hit(sel, SEL_CMD_STATUS)) begin
            state_next.irq_flag = 1'b0;
            state_next.status_symbol_ready = 1'b0;
        end
        if (ss_event_ok) begin
            state_next.irq_flag = 1'b1;
            state_next.status_symbol_ready = 1'b1;
            if (!tx_mode) begin
                state_next.received_status_symbol = status_symbol_value_in;
            end
        end
        // a finished drain or fill wins over a clear by a status read
        if (push && state_reg.core_ptr == PTR_LAST) begin
            state_next.irq_flag = 1'b1;
        end
        if (state_reg.engine == ENG_FILL && core_block_done_in) begin
            state_next.irq_flag = 1'b1;
        end

        // read data mux; the fourth read address returns zero
        case (sel)
            SEL_DATA: state_next.rd_data = state_reg.buf_mem[state_reg.host_ptr];
            SEL_CMD_STATUS: begin
                state_next.rd_data = RESET_BYTE;
                state_next.rd_data[STS_IRQ] = state_reg.irq_flag;
                state_next.rd_data[STS_BUFFER_FREE_FLAG] = state_reg.buffer_free_flag;
                state_next.rd_data[STS_STATUS_SYMBOL_READY] = state_reg.status_symbol_ready;
                state_next.rd_data[STS_RECEIVED_STATUS_SYMBOL_HI:STS_RECEIVED_STATUS_SYMBOL_LO] = state_reg.received_status_symbol;
            end
            SEL_CTRL_QUALITY: state_next.rd_data = signal_quality_in;
            default: state_next.rd_data = RESET_BYTE;
        endcase

        // settle counter after leaving powersave
        if (state_reg.mode_reg[MOD_POWER_SAVE] && !state_next.mode_reg[MOD_POWER_SAVE]) begin
            state_next.settle_count = SETTLE_SYMBOLS;
        end else if (state_next.mode_reg[MOD_POWER_SAVE]) begin
            state_next.settle_count = SETTLE_SYMBOLS;
        end else if (symbol_tick_in && state_reg.settle_count != 5'h00) begin
            state_next.settle_count = state_reg.settle_count - 1'b1;
        end

        sym = state_reg.mode_reg[MOD_NEXT_STATUS_SYMBOL_HI:MOD_NEXT_STATUS_SYMBOL_LO];
        if (two_level) begin
            sym[MOD_NEXT_STATUS_SYMBOL_LO] = 1'b0;
        end
        next_status_symbol_out = tx_mode ? sym : 2'h0;

        // synchronous reset clears every field except buffer_free_flag, which it sets
        if (rst_in) begin
            state_next = '0;
            state_next.buffer_free_flag = 1'b1;
            state_next.engine = ENG_IDLE;
            state_next.settle_count = 5'h00;
        end
    end

    // one register stage for the whole state
    always_ff @(posedge clk_in) begin
        state_reg <= state_next;
    end

    // decoded control outputs
    // read data comes straight from its flip-flops
    assign rd_data_out = state_reg.rd_data;

    // pin pulled low only while enabled and flagged
    assign interrupt_pin_n_out = !(state_reg.mode_reg[MOD_IRQEN] && state_reg.irq_flag);

    // transmit words offered from the buffer head
    assign core_word_valid_out = skid_out_valid;

    // head word of the buffer
    assign core_word_out = state_reg.skid_data[state_reg.skid_rd];

    // receive words accepted while filling
    assign core_word_ready_out = (state_reg.engine == ENG_FILL);

    // task code held for the core
    assign task_code_out = state_reg.task_reg;

    // start strobe for the core
    assign task_start_out = state_reg.task_start;

    // cancel strobe for the core
    assign task_cancel_out = state_reg.task_cancel;

    // crystal to symbol divide ratio
    assign symbol_divide_out = divide_ratio(
        state_reg.control_reg[CTL_CLOCK_DIVIDE_SELECT_HI:CTL_CLOCK_DIVIDE_SELECT_LO], two_level);

    // alternate checksum only counts in four-level
    assign alternate_checksum_select_out = state_reg.control_reg[CTL_ALTERNATE_CHECKSUM_SELECT] && !two_level;

    // alternate filter only counts in four-level
    assign alternate_filter_select_out = state_reg.control_reg[CTL_ALTERNATE_FILTER_SELECT] && !two_level;

    // two-level operation
    assign two_level_mode_out = two_level;

    // sync detector error budget
    assign sync_error_tolerance_out = two_level ? TOL2
        : (state_reg.control_reg[CTL_TOL] ? TOL4_HIGH : TOL4_LOW);

    // freeze of level and timing correction
    assign level_timing_hold_out = state_reg.control_reg[CTL_HOLD];

    // symbol polarity inversion
    assign invert_polarity_out = state_reg.mode_reg[MOD_INVERT];

    // transmit direction
    assign transmit_select_out = tx_mode;

    // whole device powered down
    assign zero_power_out = state_reg.mode_reg[MOD_ZP];

    // filters and extraction off, also under zero power
    assign power_save_out = state_reg.mode_reg[MOD_POWER_SAVE] || state_reg.mode_reg[MOD_ZP];

    // output valid once the settle count has run out
    assign output_settled_out = !power_save_out && (state_reg.settle_count == 5'h00);
endmodule

// file: core_model.sv
/*
 * modem core stand-in: sinks transmit words with stalls, sources receive words.
 * assumes the host register bank drives and samples on the rising clk_in edge.
 */
`timescale 1ns/1ps
module core_model (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic send_in,
    input wire logic tx_valid_in,
    input wire logic [7:0] tx_word_in,
    output logic tx_ready_out,
    input wire logic rx_ready_in,
    output logic rx_valid_out,
    output logic [7:0] rx_word_out,
    output logic done_out
);
    logic [7:0] tx_log [0:11];
    logic [3:0] tx_count;
    logic [3:0] rx_count;
    logic [1:0] phase;
    // ready two cycles of four; receive word held until taken, then scrambled
    always_ff @(posedge clk_in) begin
        done_out <= 1'b0;
        if (rst_in) begin
            phase <= 2'h0;
            tx_count <= 4'h0;
            rx_count <= 4'h0;
            tx_ready_out <= 1'b0;
            rx_valid_out <= 1'b0;
            rx_word_out <= 8'h00;
        end else begin
            phase <= phase + 2'h1;
            tx_ready_out <= phase[1];
            if (tx_valid_in && tx_ready_out) begin
                tx_log[tx_count] <= tx_word_in;
                tx_count <= (tx_count == 4'hB) ? 4'h0 : tx_count + 4'h1;
            end
            if (!send_in) begin
                rx_count <= 4'h0;
            end else if (rx_valid_out && rx_ready_in) begin
                rx_valid_out <= 1'b0;
                rx_word_out <= ~rx_word_out; // no stale value after the handshake
                rx_count <= rx_count + 4'h1;
                done_out <= (rx_count == 4'hB);
            end else if (rx_count < 4'hC && !rx_valid_out && phase[0]) begin
                rx_valid_out <= 1'b1;
                rx_word_out <= 8'hA0 + {4'h0, rx_count};
            end
        end
    end
endmodule

// file: host_reg_checker.sv
/*
 * concurrent checks on the host register bank ports.
 * assumes single clock clk_in and synchronous active high rst_in.
 */
`timescale 1ns/1ps
module host_reg_checker
    import modem_host_pkg::*;
(
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic reg_select_lo_in,
    input wire logic reg_select_hi_in,
    input wire logic wr_strobe_in,
    input wire logic [7:0] wr_data_in,
    input wire logic interrupt_pin_n_out,
    input wire logic task_start_out,
    input wire logic task_cancel_out,
    input wire logic [11:0] symbol_divide_out,
    input wire logic alternate_checksum_select_out,
    input wire logic alternate_filter_select_out,
    input wire logic two_level_mode_out,
    input wire logic [2:0] sync_error_tolerance_out,
    input wire logic level_timing_hold_out,
    input wire logic invert_polarity_out,
    input wire logic transmit_select_out,
    input wire logic zero_power_out,
    input wire logic power_save_out,
    input wire logic [1:0] next_status_symbol_out
);
    logic [7:0] d_q;
    logic [1:0] sel;
    logic wc;
    logic wm;
    logic wk;
    // write decode per register
    assign sel = {reg_select_hi_in, reg_select_lo_in};
    assign wc = wr_strobe_in && sel == SEL_CTRL_QUALITY;
    assign wm = wr_strobe_in && sel == SEL_MODE;
    assign wk = wr_strobe_in && sel == SEL_CMD_STATUS;
    // last write data, for checks one cycle on
    always_ff @(posedge clk_in) begin
        d_q <= wr_data_in;
    end
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (rst_in);
    ctrl_fields_a: assert property (wc && !wr_data_in[2] |=>
        {alternate_checksum_select_out, alternate_filter_select_out, level_timing_hold_out}
        == {d_q[4], d_q[3], d_q[0]}) else $error("control fields wrong");
    divide_map_a: assert property (wc |=> symbol_divide_out ==
        ((d_q[7:6] == 2'h3 ? 12'h600 : 12'h200 + {d_q[7:6], 8'h00}) << d_q[2]))
        else $error("divide ratio wrong");
    sync_tol_a: assert property (wc |=> two_level_mode_out == d_q[2] &&
        sync_error_tolerance_out == (d_q[2] ? 3'h5 : (d_q[1] ? 3'h7 : 3'h3)))
        else $error("tolerance wrong");
    level_cancel_a: assert property (wc && wr_data_in[2] != two_level_mode_out
        |=> task_cancel_out) else $error("level change kept task");
    dir_cancel_a: assert property (wm && wr_data_in[5] != transmit_select_out
        |=> task_cancel_out) else $error("direction change kept task");
    pin_off_a: assert property (wm && !wr_data_in[7] |=> interrupt_pin_n_out)
        else $error("pin low while disabled");
    mode_fields_a: assert property (wm |=> {invert_polarity_out, transmit_select_out,
        zero_power_out, power_save_out} == {d_q[6], d_q[5], d_q[4], d_q[4] | d_q[3]})
        else $error("mode fields wrong");
    next_sym_a: assert property (wm |=> next_status_symbol_out ==
        (d_q[5] ? {d_q[1], d_q[0] & !two_level_mode_out} : 2'h0))
        else $error("next symbol wrong");
    zp_ignore_a: assert property (wk && zero_power_out |=> !task_start_out)
        else $error("command taken in zero power");
    task_go_a: assert property (wk && !zero_power_out && wr_data_in[2:0] inside {[1:6]}
        |=> task_start_out) else $error("task not started");
    tx_mode_c: cover property (wm && wr_data_in[5]);
    task_c: cover property (task_start_out);
    irq_c: cover property (!interrupt_pin_n_out);
endmodule
bind packet_modem_host_registers host_reg_checker host_reg_checker_inst (.*);

// file: testbench.sv
/*
 * self-checking bench for the host register bank, with the core stand-in.
 * assumes 8 ns clk_in and reads shown one edge after they are taken.
 */
`timescale 1ns/1ps
`define CHECK(a, b) begin checked++; if ((a) !== (b)) begin miscompares++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (b)); end end
module testbench;
    import modem_host_pkg::*;
    logic clk_in = 0, rst_in = 1, wr_s = 0, rd_s = 0, ev = 0, tick = 0, send = 0;
    logic [1:0] sel = 0, nsym;
    logic [6:0] ev_idx = 0;
    logic [7:0] wd = 0, rdat, rbus, txw, rxw, quality = 8'h5A;
    logic pin, txv, txr, rxv, rxr, done, two, ps, settled, ac, af, hold;
    logic [11:0] divide, b;
    logic [2:0] tol;
    int miscompares = 0, checked = 0, cycles = 0;
    packet_modem_host_registers packet_modem_host_registers_inst (.clk_in(clk_in),
        .rst_in(rst_in), .reg_select_lo_in(sel[0]), .reg_select_hi_in(sel[1]),
        .wr_strobe_in(wr_s), .rd_strobe_in(rd_s), .wr_data_in(wd), .rd_data_out(rbus),
        .interrupt_pin_n_out(pin), .core_word_valid_out(txv), .core_word_ready_in(txr),
        .core_word_out(txw), .core_word_valid_in(rxv), .core_word_ready_out(rxr),
        .core_word_in(rxw), .core_block_done_in(done), .status_symbol_event_in(ev),
        .status_symbol_value_in(ev_idx[1:0]), .block_bit_index_in(ev_idx),
        .symbol_tick_in(tick),
        .signal_quality_in(quality), .task_code_out(), .task_start_out(),
        .task_cancel_out(), .symbol_divide_out(divide), .alternate_checksum_select_out(ac),
        .alternate_filter_select_out(af), .two_level_mode_out(two),
        .sync_error_tolerance_out(tol), .level_timing_hold_out(hold),
        .invert_polarity_out(), .transmit_select_out(), .zero_power_out(),
        .power_save_out(ps), .output_settled_out(settled), .next_status_symbol_out(nsym));
    core_model core_model_inst (.clk_in(clk_in), .rst_in(rst_in), .send_in(send),
        .tx_valid_in(txv), .tx_word_in(txw), .tx_ready_out(txr), .rx_ready_in(rxr),
        .rx_valid_out(rxv), .rx_word_out(rxw), .done_out(done));
    // clock and hang guard
    always #4 clk_in = ~clk_in;
    always @(posedge clk_in) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            miscompares++;
            complete_run();
        end
    end
    task automatic complete_run();
        $display("checked=%0d miscompares=%0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // one bus access, two cycles, read data caught mid cycle after the taking edge
    task automatic access(input logic [1:0] a, input logic w, input logic [7:0] d);
        sel <= a;
        wd <= d;
        wr_s <= w;
        rd_s <= !w;
        @(posedge clk_in);
        wr_s <= 0;
        rd_s <= 0;
        @(negedge clk_in);
        rdat = rbus;
        @(posedge clk_in);
    endtask
    task automatic wr(input logic [1:0] a, input logic [7:0] d);
        access(a, 1'b1, d);
    endtask
    task automatic rd(input logic [1:0] a, input logic [7:0] e, input logic [7:0] m);
        access(a, 1'b0, 8'h00);
        `CHECK(rdat & m, e)
    endtask
    task automatic pulse(input logic s, input logic [6:0] idx);
        ev <= s;
        tick <= !s;
        ev_idx <= idx;
        @(posedge clk_in);
        ev <= 0;
        tick <= 0;
        @(posedge clk_in);
    endtask
    task automatic wait_pin();
        for (int n = 0; n < 400 && pin !== 1'b0; n++) @(posedge clk_in);
    endtask
    // main sequence
    initial begin
        repeat (5) @(posedge clk_in);
        rst_in <= 0;
        @(posedge clk_in);
        @(negedge clk_in);
        `CHECK({pin, divide, tol, two}, {1'b1, 12'h200, 3'h3, 1'b0})
        @(posedge clk_in);
        rd(SEL_CMD_STATUS, 8'h40, 8'hFF);
        rd(SEL_MODE, 8'h00, 8'hFF);
        rd(SEL_CTRL_QUALITY, 8'h5A, 8'hFF);
        wr(SEL_MODE, 8'hC0);
        $display("test reset done");
        for (int i = 0; i < 16; i++) begin
            wr(SEL_CTRL_QUALITY, {i[1:0], 1'b0, {2{i[3] & !i[2]}}, i[2], i[3], i[3]});
            b = (i[1:0] == 2'h3) ? 12'h600 : 12'h200 + {2'h0, i[1:0], 8'h00};
            `CHECK(divide, b << i[2])
            `CHECK(tol, i[2] ? 3'h5 : (i[3] ? 3'h7 : 3'h3))
            `CHECK({two, ac, af, hold}, {i[2], {2{i[3] & !i[2]}}, i[3]})
        end
        wr(SEL_CTRL_QUALITY, 8'h00);
        $display("test control done");
        wr(SEL_MODE, 8'hA0);
        for (int i = 0; i < 12; i++) wr(SEL_DATA, 8'h10 + 8'(i));
        wr(SEL_CMD_STATUS, 8'h02);
        rd(SEL_CMD_STATUS, 8'h00, 8'h40);
        wait_pin();
        rd(SEL_CMD_STATUS, 8'hC0, 8'hE0);
        `CHECK(pin, 1'b1)
        repeat (4) @(posedge clk_in);
        for (int i = 0; i < 12; i++) `CHECK(core_model_inst.tx_log[i], 8'h10 + 8'(i))
        $display("test transmit done");
        wr(SEL_MODE, 8'h80);
        wr(SEL_CMD_STATUS, 8'h02);
        send <= 1;
        wait_pin();
        rd(SEL_CMD_STATUS, 8'hC0, 8'hE0);
        send <= 0;
        for (int i = 0; i < 12; i++) rd(SEL_DATA, 8'hA0 + 8'(i), 8'hFF);
        $display("test receive done");
        wr(SEL_MODE, 8'h84);
        pulse(1'b1, 7'h02);
        rd(SEL_CMD_STATUS, 8'hE2, 8'hFF);
        wr(SEL_CTRL_QUALITY, 8'h04);
        pulse(1'b1, 7'd93);
        rd(SEL_CMD_STATUS, 8'h40, 8'hE0);
        wr(SEL_MODE, 8'hA7);
        `CHECK(nsym, 2'h2)
        pulse(1'b1, 7'h00);
        rd(SEL_CMD_STATUS, 8'hE0, 8'hE0);
        $display("test symbols done");
        wr(SEL_MODE, 8'h10);
        wr(SEL_CMD_STATUS, 8'h02);
        rd(SEL_CMD_STATUS, 8'h40, 8'h40);
        wr(SEL_MODE, 8'h08);
        `CHECK(ps, 1'b1)
        wr(SEL_MODE, 8'h00);
        for (int i = 1; i <= 20; i++) begin
            pulse(1'b0, 7'h00);
            `CHECK(settled, i == 20)
        end
        $display("test power done");
        complete_run();
    end
endmodule
